// ===== hdl/axis_fault_map.svh
// Register offsets, fault codes and limits for the axis fault monitor
`ifndef AXIS_FAULT_MAP_SVH
`define AXIS_FAULT_MAP_SVH
`define X_AXIS_FAULT_CODE_OFFSET 8'h0F
`define Y_AXIS_FAULT_CODE_OFFSET 8'h10
`define AXIS_STATUS_OFFSET 8'h11
`define FAULT_CODE_RESET 16'h0000
`define CODE_NONE 16'h0000
`define CODE_DRV_ALARM 16'h0060
`define CODE_ERR_CNT_OVF 16'h0061
`define CODE_CW_OVERTRAVEL 16'h0062
`define CODE_CCW_OVERTRAVEL 16'h0063
`define CODE_BOTH_OVERTRAVEL 16'h0064
`define ERR_CNT_LIMIT 17'h0FFFF
`define STATUS_X_HELD_BIT 0
`define STATUS_Y_HELD_BIT 1
`define STATUS_X_REJECT_BIT 2
`define STATUS_Y_REJECT_BIT 3
`endif

// ===== hdl/axis_fault_pkg.sv
// Types for the axis fault monitor
package axis_fault_pkg;
    typedef enum logic [0:0] {
        AXIS_CLEAR = 1'b0,
        AXIS_HELD = 1'b1
    } axis_state_t;
endpackage

// ===== hdl/axis_fault_channel.sv
// One axis: fault detection, code hold and command gating
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "axis_fault_map.svh"
module axis_fault_channel (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Axis inputs
    input wire logic drv_alarm,
    input wire logic cw_limit,
    input wire logic ccw_limit,
    input wire logic moving,
    input wire logic [16:0] err_count,
    input wire logic err_reset,
    input wire logic cmd_req,
    // Results
    output logic [15:0] code,
    output logic held,
    output logic cmd_accept,
    output logic cmd_reject
);
    typedef struct packed {
        axis_fault_pkg::axis_state_t state;
        logic [15:0] code;
        logic accept;
        logic reject;
    } chan_t;

    chan_t cur_reg;
    chan_t cur_next;
    logic [15:0] live_code;

    // Priority: alarm, counter overflow, then limit switches
    always_comb begin
        live_code = `CODE_NONE;
        if (drv_alarm) begin
            live_code = `CODE_DRV_ALARM;
        end else if (err_count > `ERR_CNT_LIMIT) begin
            live_code = `CODE_ERR_CNT_OVF;
        end else if (cw_limit && ccw_limit) begin
            live_code = `CODE_BOTH_OVERTRAVEL;
        end else if (cw_limit) begin
            live_code = `CODE_CW_OVERTRAVEL;
        end else if (ccw_limit) begin
            live_code = `CODE_CCW_OVERTRAVEL;
        end
    end

    always_comb begin
        cur_next = cur_reg;
        cur_next.accept = 1'b0;
        cur_next.reject = 1'b0;
        case (cur_reg.state)
            axis_fault_pkg::AXIS_CLEAR: begin
                if (cmd_req && live_code != `CODE_NONE) begin
                    // Still faulted after reset: refuse and re-report
                    cur_next.reject = 1'b1;
                    cur_next.code = live_code;
                    cur_next.state = axis_fault_pkg::AXIS_HELD;
                end else if (drv_alarm || live_code == `CODE_ERR_CNT_OVF
                        || (moving && live_code != `CODE_NONE)) begin
                    cur_next.code = live_code;
                    cur_next.state = axis_fault_pkg::AXIS_HELD;
                    cur_next.reject = cmd_req;
                end else begin
                    cur_next.accept = cmd_req;
                end
            end
            axis_fault_pkg::AXIS_HELD: begin
                cur_next.reject = cmd_req;
                if (err_reset) begin
                    cur_next.code = `CODE_NONE;
                    cur_next.state = axis_fault_pkg::AXIS_CLEAR;
                end
            end
            default: begin
                cur_next.state = axis_fault_pkg::AXIS_CLEAR;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur_reg <= '{axis_fault_pkg::AXIS_CLEAR, `FAULT_CODE_RESET,
                1'b0, 1'b0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign code = cur_reg.code;
    assign held = (cur_reg.state == axis_fault_pkg::AXIS_HELD);
    assign cmd_accept = cur_reg.accept;
    assign cmd_reject = cur_reg.reject;

    alarm_code_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!held && drv_alarm && !err_reset) |=> code == 16'h0060)
        else $error("alarm did not report 0060");
    hold_code_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (held && !err_reset) |=> $stable(code) && held)
        else $error("held code changed without reset");
    held_reject_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (held && cmd_req) |=> cmd_reject && !cmd_accept)
        else $error("command accepted while held");
    ovf_code_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!held && !drv_alarm && err_count > 17'h0FFFF) |=>
        code == 16'h0061)
        else $error("counter overflow did not report 0061");
    both_limit_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!held && !drv_alarm && err_count <= 17'h0FFFF && moving
        && cw_limit && ccw_limit) |=> code == 16'h0064)
        else $error("both limits did not report 0064");
    cw_limit_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!held && !drv_alarm && err_count <= 17'h0FFFF && moving
        && cw_limit && !ccw_limit) |=> code == 16'h0062)
        else $error("cw limit did not report 0062");
    ccw_limit_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!held && !drv_alarm && err_count <= 17'h0FFFF && moving
        && !cw_limit && ccw_limit) |=> code == 16'h0063)
        else $error("ccw limit did not report 0063");
    retry_reject_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!held && cmd_req && (cw_limit || ccw_limit || drv_alarm)) |=>
        cmd_reject && held)
        else $error("command with live fault not rejected");
    reset_release_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (held && err_reset) |=> !held ##0 code == 16'h0000)
        else $error("error reset did not release axis");
endmodule // axis_fault_channel

// ===== hdl/axis_fault_monitor.sv
// Two-axis fault monitor with register read port
// Functional notes
// - X fault code goes to word 0x0F, Y fault code to word 0x10.
// - Driver alarm on flags an axis fault with code 0060.
// - Alarm still on after reset: command rejected, code 0060 again.
// - Error counter beyond 65,535 pulses raises code 0061.
// - CW limit on while moving raises code 0062.
// - CW limit still on after reset and command: code 0062 again.
// - CCW limit on while moving raises code 0063.
// - CCW limit still on after reset and command: code 0063 again.
// - Both limits on while moving raise code 0064.
// - Both limits still on after reset and command: 0064 again.
`timescale 1ns/1ps
`include "axis_fault_map.svh"
module axis_fault_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Axis inputs, index 0 = X, 1 = Y
    input wire logic [1:0] drv_alarm,
    input wire logic [1:0] cw_limit,
    input wire logic [1:0] ccw_limit,
    input wire logic [1:0] moving,
    input wire logic [16:0] x_err_count,
    input wire logic [16:0] y_err_count,
    input wire logic [1:0] err_reset,
    input wire logic [1:0] cmd_req,
    // Command outcome and status
    output logic [1:0] cmd_accept,
    output logic [1:0] cmd_reject,
    output logic [1:0] axis_fault
);
    typedef struct packed {
        logic [15:0] rdata;
        logic [1:0] accept;
        logic [1:0] reject;
        logic [1:0] fault;
    } top_t;

    top_t cur_reg;
    top_t cur_next;
    logic [15:0] code [2];
    logic [1:0] held;
    logic [1:0] acc;
    logic [1:0] rej;
    logic [16:0] cnt [2];

    assign cnt[0] = x_err_count;
    assign cnt[1] = y_err_count;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_axis
            axis_fault_channel u_chan (
                .ref_clk(ref_clk),
                .rst(rst),
                .drv_alarm(drv_alarm[i]),
                .cw_limit(cw_limit[i]),
                .ccw_limit(ccw_limit[i]),
                .moving(moving[i]),
                .err_count(cnt[i]),
                .err_reset(err_reset[i]),
                .cmd_req(cmd_req[i]),
                .code(code[i]),
                .held(held[i]),
                .cmd_accept(acc[i]),
                .cmd_reject(rej[i])
            );
        end
    endgenerate

    // Read port; writes have no effect, registers are read-only
    always_comb begin
        cur_next = cur_reg;
        cur_next.rdata = 16'h0000;
        cur_next.accept = acc;
        cur_next.reject = rej;
        cur_next.fault = held;
        if (reg_rd) begin
            case (reg_addr)
                `X_AXIS_FAULT_CODE_OFFSET: cur_next.rdata = code[0];
                `Y_AXIS_FAULT_CODE_OFFSET: cur_next.rdata = code[1];
                `AXIS_STATUS_OFFSET: begin
                    cur_next.rdata = {12'h000, rej, held};
                end
                default: cur_next.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign reg_rdata = cur_reg.rdata;
    assign cmd_accept = cur_reg.accept;
    assign cmd_reject = cur_reg.reject;
    assign axis_fault = cur_reg.fault;

    x_word_read_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == 8'h0F) |=> reg_rdata == $past(code[0]))
        else $error("X word read mismatch");
    y_word_read_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == 8'h10) |=> reg_rdata == $past(code[1]))
        else $error("Y word read mismatch");
endmodule // axis_fault_monitor

// ===== dv/host_reader.sv
// Host controller model reading and writing the fault words
`timescale 1ns/1ps
module host_reader (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One strobe cycle, read data taken in the cycle after it
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [15:0] wd, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= wd;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask
endmodule // host_reader

// ===== dv/axis_fault_monitor_tb.sv
// Self-checking bench for the two-axis fault monitor
`timescale 1ns/1ps
`include "axis_fault_map.svh"
module axis_fault_monitor_tb;
    typedef struct packed {
        logic a;
        logic al;
        logic cw;
        logic ccw;
        logic mv;
        logic [16:0] cnt;
        logic [15:0] code;
    } row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd;
    logic [1:0] drv_alarm = 2'h0, cw_limit = 2'h0, ccw_limit = 2'h0;
    logic [1:0] moving = 2'h0, err_reset = 2'h0, cmd_req = 2'h0;
    logic [1:0] cmd_accept, cmd_reject, axis_fault;
    logic [16:0] x_err_count = 17'h00000, y_err_count = 17'h00000;
    int n_errors = 0;
    int compares = 0;
    int rl[4] = '{0, 3, 4, 5};
    row_t rows[7] = '{
        '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, '0, `CODE_DRV_ALARM},
        '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 17'h10000, `CODE_ERR_CNT_OVF},
        '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 17'h0FFFF, `CODE_NONE},
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, '0, `CODE_CW_OVERTRAVEL},
        '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, '0, `CODE_CCW_OVERTRAVEL},
        '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, '0, `CODE_BOTH_OVERTRAVEL},
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, '0, `CODE_NONE}};
    axis_fault_monitor u_dut (.ref_clk, .rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .drv_alarm, .cw_limit, .ccw_limit,
        .moving, .x_err_count, .y_err_count, .err_reset, .cmd_req,
        .cmd_accept, .cmd_reject, .axis_fault);
    host_reader u_host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata);
    initial forever #2 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input string n, input logic a, input logic [15:0] e);
        logic [15:0] v;
        u_host.acc(1'b0, a ? `Y_AXIS_FAULT_CODE_OFFSET
                           : `X_AXIS_FAULT_CODE_OFFSET, 16'h0000, v);
        chk(n, v, e);
    endtask
    task automatic put(input row_t r);
        @(posedge ref_clk);
        drv_alarm[r.a] <= r.al;
        cw_limit[r.a] <= r.cw;
        ccw_limit[r.a] <= r.ccw;
        moving[r.a] <= r.mv;
        if (r.a) y_err_count <= r.cnt;
        else x_err_count <= r.cnt;
    endtask
    // Drop every fault input and pulse both error resets
    task automatic clr();
        @(posedge ref_clk);
        {drv_alarm, cw_limit, ccw_limit, moving} <= 8'h00;
        x_err_count <= '0;
        y_err_count <= '0;
        err_reset <= 2'h3;
        @(posedge ref_clk);
        err_reset <= 2'h0;
    endtask
    task automatic cmd(input logic a, input logic [1:0] e);
        @(posedge ref_clk);
        cmd_req[a] <= 1'b1;
        @(posedge ref_clk);
        cmd_req[a] <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("cmd", {14'h0, cmd_accept[a], cmd_reject[a]}, {14'h0, e});
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rchk("x reset", 1'b0, `FAULT_CODE_RESET);
        $display("test reset done");
        foreach (rows[i]) begin
            put(rows[i]);
            rchk("code", rows[i].a, rows[i].code);
            rchk("other", !rows[i].a, `CODE_NONE);
            clr();
            rchk("cleared", rows[i].a, `CODE_NONE);
        end
        $display("test table done");
        foreach (rl[k]) begin
            put(rows[rl[k]]);
            @(posedge ref_clk);
            moving <= 2'h0;
            err_reset[rows[rl[k]].a] <= 1'b1;
            @(posedge ref_clk);
            err_reset <= 2'h0;
            cmd(rows[rl[k]].a, 2'b01);
            rchk("again", rows[rl[k]].a, rows[rl[k]].code);
            clr();
        end
        $display("test relatch done");
        put(rows[3]);
        clr_hold();
        $display("test hold done");
        u_host.acc(1'b1, `X_AXIS_FAULT_CODE_OFFSET, 16'hFFFF, d);
        rchk("ro word", 1'b0, `CODE_NONE);
        u_host.acc(1'b0, 8'h20, 16'h0000, d);
        chk("unmapped", d, 16'h0000);
        // Y off its CCW switch by a clockwise manual move, then reset
        put(rows[4]);
        @(posedge ref_clk);
        ccw_limit <= 2'h0;
        err_reset <= 2'h2;
        @(posedge ref_clk);
        err_reset <= 2'h0;
        moving <= 2'h0;
        cmd(1'b1, 2'b10);
        rchk("recovered", 1'b1, `CODE_NONE);
        $display("test recover done");
        put(rows[0]);
        @(posedge ref_clk);
        drv_alarm <= 2'h0;
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rchk("rst code", 1'b0, `FAULT_CODE_RESET);
        chk("rst fault", {14'h0, axis_fault}, 16'h0000);
        $display("test midreset done");
        end_sim();
    end
    // Code and fault flag outlive the cause until error reset
    task automatic clr_hold();
        @(posedge ref_clk);
        cw_limit <= 2'h0;
        moving <= 2'h0;
        rchk("held", 1'b0, `CODE_CW_OVERTRAVEL);
        chk("fault", {14'h0, axis_fault}, 16'h0001);
        u_host.acc(1'b0, `AXIS_STATUS_OFFSET, 16'h0000, d);
        chk("status", d, 16'h0001);
        cmd(1'b0, 2'b01);
        cmd(1'b1, 2'b10);
        clr();
        cmd(1'b0, 2'b10);
    endtask
endmodule // axis_fault_monitor_tb
